/* File: dbrt_table.v */
// debug component lookup table behind a debug peripheral bus slave
`include "dbrt_map.vh"
`default_nettype none

module dbrt_table #(
  parameter integer CORE_COUNT = `DBRT_CORE_COUNT_DEF
) (
  // clock and reset
  input wire mclk_i,
  input wire resetn_i,
  // debug peripheral bus slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [`DBRT_ADDR_W-1:0] paddr_i,
  input wire [`DBRT_DATA_W-1:0] pwdata_i,
  input wire [3:0] pstrb_i,
  output wire [`DBRT_DATA_W-1:0] prdata_o,
  output wire pready_o,
  output wire pslverr_o
);

  // ----------------------------------------------------------------------
  // build-time population of the core-dependent entries
  // ----------------------------------------------------------------------
  // fixed at elaboration: no write or reset can change a word afterwards
  localparam [0:0] HAS_CORE1 = (CORE_COUNT >= `DBRT_MIN_CORES_E3);
  localparam [0:0] HAS_CORE2 = (CORE_COUNT >= `DBRT_MIN_CORES_E4);
  localparam [0:0] HAS_CORE3 = (CORE_COUNT >= `DBRT_MIN_CORES_E5);
  localparam [0:0] HAS_CORE4 = (CORE_COUNT >= `DBRT_MIN_CORES_E6);

  // ----------------------------------------------------------------------
  // constant entries
  // ----------------------------------------------------------------------
  wire [31:0] ent0;
  wire [31:0] ent1;
  wire [31:0] ent2;
  wire [31:0] ent3;
  wire [31:0] ent4;
  wire [31:0] ent5;
  wire [31:0] ent6;

  dbrt_entry #(
    .COMP_OFS(`DBRT_CO_CLUSTER_ROM),
    .PDC_VALID(1'h1),
    .PDC(`DBRT_CLUSTER_POWER_DOMAIN),
    .POPULATED(1'h1)
  ) u_ent0 (
    .entry_o(ent0)
  );

  dbrt_entry #(
    .COMP_OFS(`DBRT_CO_CLUSTER_TRIGGER),
    .PDC_VALID(1'h0),
    .PDC(5'h00),
    .POPULATED(1'h1)
  ) u_ent1 (
    .entry_o(ent1)
  );

  dbrt_entry #(
    .COMP_OFS(`DBRT_CO_CORE0_TRIGGER),
    .PDC_VALID(1'h0),
    .PDC(5'h00),
    .POPULATED(1'h1)
  ) u_ent2 (
    .entry_o(ent2)
  );

  dbrt_entry #(
    .COMP_OFS(`DBRT_CO_CORE1_TRIGGER),
    .PDC_VALID(1'h0),
    .PDC(5'h00),
    .POPULATED(HAS_CORE1)
  ) u_ent3 (
    .entry_o(ent3)
  );

  dbrt_entry #(
    .COMP_OFS(`DBRT_CO_CORE2_TRIGGER),
    .PDC_VALID(1'h0),
    .PDC(5'h00),
    .POPULATED(HAS_CORE2)
  ) u_ent4 (
    .entry_o(ent4)
  );

  dbrt_entry #(
    .COMP_OFS(`DBRT_CO_CORE3_TRIGGER),
    .PDC_VALID(1'h0),
    .PDC(5'h00),
    .POPULATED(HAS_CORE3)
  ) u_ent5 (
    .entry_o(ent5)
  );

  dbrt_entry #(
    .COMP_OFS(`DBRT_CO_CORE4_TRIGGER),
    .PDC_VALID(1'h0),
    .PDC(5'h00),
    .POPULATED(HAS_CORE4)
  ) u_ent6 (
    .entry_o(ent6)
  );

  // ----------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------
  // byte lanes play no part: every entry is read as one whole word
  wire [`DBRT_ADDR_W-1:0] word_addr;
  wire hit0;
  wire hit1;
  wire hit2;
  wire hit3;
  wire hit4;
  wire hit5;
  wire hit6;

  assign word_addr = {paddr_i[`DBRT_IDX_MSB:`DBRT_IDX_LSB], 2'h0};
  assign hit0 = (word_addr == `DBRT_OFS_CLUSTER_ROM);
  assign hit1 = (word_addr == `DBRT_OFS_CLUSTER_TRIGGER);
  assign hit2 = (word_addr == `DBRT_OFS_CORE0_TRIGGER);
  assign hit3 = (word_addr == `DBRT_OFS_CORE1_TRIGGER);
  assign hit4 = (word_addr == `DBRT_OFS_CORE2_TRIGGER);
  assign hit5 = (word_addr == `DBRT_OFS_CORE3_TRIGGER);
  assign hit6 = (word_addr == `DBRT_OFS_CORE4_TRIGGER);

  // ----------------------------------------------------------------------
  // read data select
  // ----------------------------------------------------------------------
  // hits exclude each other, so an and-or tree needs no priority chain
  wire [`DBRT_DATA_W-1:0] sel_word;

  assign sel_word = ({`DBRT_DATA_W{hit0}} & ent0) |
    ({`DBRT_DATA_W{hit1}} & ent1) |
    ({`DBRT_DATA_W{hit2}} & ent2) |
    ({`DBRT_DATA_W{hit3}} & ent3) |
    ({`DBRT_DATA_W{hit4}} & ent4) |
    ({`DBRT_DATA_W{hit5}} & ent5) |
    ({`DBRT_DATA_W{hit6}} & ent6);

  // ----------------------------------------------------------------------
  // transfer phase tracking
  // ----------------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_RD_ACCESS = 3'b010;
  localparam [2:0] ST_WR_ACCESS = 3'b100;

  reg [2:0] state_q;
  reg [2:0] state_d;
  wire setup_any;
  wire setup_rd;
  wire setup_wr;

  // penable is low only in the setup phase, so each transfer is taken once
  assign setup_any = psel_i & ~penable_i;
  assign setup_rd = setup_any & ~pwrite_i;
  assign setup_wr = setup_any & pwrite_i;

  // the access cycle always lasts one clock; a setup may follow it at once
  always @*
  begin
    case (state_q)
      ST_IDLE:
      begin
        if (setup_rd)
        begin
          state_d = ST_RD_ACCESS;
        end
        else if (setup_wr)
        begin
          state_d = ST_WR_ACCESS;
        end
        else
        begin
          state_d = ST_IDLE;
        end
      end
      ST_RD_ACCESS:
      begin
        if (setup_rd)
        begin
          state_d = ST_RD_ACCESS;
        end
        else if (setup_wr)
        begin
          state_d = ST_WR_ACCESS;
        end
        else
        begin
          state_d = ST_IDLE;
        end
      end
      ST_WR_ACCESS:
      begin
        if (setup_rd)
        begin
          state_d = ST_RD_ACCESS;
        end
        else if (setup_wr)
        begin
          state_d = ST_WR_ACCESS;
        end
        else
        begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------------
  // answer registers
  // ----------------------------------------------------------------------
  reg [`DBRT_DATA_W-1:0] prdata_q;
  reg [`DBRT_DATA_W-1:0] prdata_d;
  reg pready_q;
  reg pready_d;
  reg pslverr_q;

  // data only shown on a read access; writes and idle cycles return zero
  always @*
  begin
    pready_d = 1'h0;
    prdata_d = `DBRT_ZERO_WORD;
    case (state_d)
      ST_RD_ACCESS:
      begin
        pready_d = 1'h1;
        prdata_d = sel_word;
      end
      ST_WR_ACCESS:
      begin
        // write data and strobes have no destination: nothing is writable
        pready_d = 1'h1;
      end
      default:
      begin
        pready_d = 1'h0;
      end
    endcase
  end

  always @(posedge mclk_i)
  begin
    if (!resetn_i)
    begin
      state_q <= ST_IDLE;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  always @(posedge mclk_i)
  begin
    if (!resetn_i)
    begin
      pready_q <= 1'h0;
      prdata_q <= `DBRT_ZERO_WORD;
    end
    else
    begin
      pready_q <= pready_d;
      prdata_q <= prdata_d;
    end
  end

  // no request is ever refused, writes and unmapped words included
  always @(posedge mclk_i)
  begin
    if (!resetn_i)
    begin
      pslverr_q <= 1'h0;
    end
    else
    begin
      pslverr_q <= 1'h0;
    end
  end

  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;

endmodule // dbrt_table
`default_nettype wire

/* File: dbrt_map.vh */
// address map, field layout and fixed values of the debug lookup table
`ifndef DBRT_MAP_VH
`define DBRT_MAP_VH

// ----------------------------------------------------------------------
// bus geometry
// ----------------------------------------------------------------------
`define DBRT_ADDR_W 12
`define DBRT_DATA_W 32
`define DBRT_IDX_MSB 11
`define DBRT_IDX_LSB 2
`define DBRT_IDX_W 10

// ----------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------
`define DBRT_OFS_CLUSTER_ROM 12'h000
`define DBRT_OFS_CLUSTER_TRIGGER 12'h004
`define DBRT_OFS_CORE0_TRIGGER 12'h008
`define DBRT_OFS_CORE1_TRIGGER 12'h00C
`define DBRT_OFS_CORE2_TRIGGER 12'h010
`define DBRT_OFS_CORE3_TRIGGER 12'h014
`define DBRT_OFS_CORE4_TRIGGER 12'h018

// ----------------------------------------------------------------------
// entry field layout
// ----------------------------------------------------------------------
`define DBRT_COMP_OFS_MSB 31
`define DBRT_COMP_OFS_LSB 12
`define DBRT_COMP_OFS_W 20
`define DBRT_PDC_MSB 8
`define DBRT_PDC_LSB 4
`define DBRT_PDC_W 5
`define DBRT_PDC_VALID_BIT 2
`define DBRT_PRESENCE_MSB 1
`define DBRT_PRESENCE_LSB 0
`define DBRT_PRESENCE_W 2
`define DBRT_PRESENCE_YES 2'h3

// ----------------------------------------------------------------------
// entry contents
// ----------------------------------------------------------------------
`define DBRT_CO_CLUSTER_ROM 20'h000C0
`define DBRT_CO_CLUSTER_TRIGGER 20'h000F0
`define DBRT_CO_CORE0_TRIGGER 20'h000F0
`define DBRT_CO_CORE1_TRIGGER 20'h00170
`define DBRT_CO_CORE2_TRIGGER 20'h001F0
`define DBRT_CO_CORE3_TRIGGER 20'h00270
`define DBRT_CO_CORE4_TRIGGER 20'h002F0
`define DBRT_CLUSTER_POWER_DOMAIN 5'h00

// least core count at which each core-dependent entry is populated
`define DBRT_MIN_CORES_E3 2
`define DBRT_MIN_CORES_E4 3
`define DBRT_MIN_CORES_E5 4
`define DBRT_MIN_CORES_E6 5
`define DBRT_CORE_COUNT_DEF 14

`define DBRT_ZERO_WORD 32'h00000000

`endif

/* File: dbrt_entry.v */
// one table entry assembled from its constant fields
`include "dbrt_map.vh"
`default_nettype none

module dbrt_entry #(
  parameter [19:0] COMP_OFS = 20'h00000,
  parameter [0:0] PDC_VALID = 1'h0,
  parameter [4:0] PDC = 5'h00,
  parameter [0:0] POPULATED = 1'h1
) (
  // descriptor word
  output wire [31:0] entry_o
);

  // unpopulated entries collapse to all reserved zero bits
  assign entry_o = POPULATED ?
    {COMP_OFS, 3'h0, PDC, 1'h0, PDC_VALID, `DBRT_PRESENCE_YES} :
    `DBRT_ZERO_WORD;

endmodule // dbrt_entry
`default_nettype wire

/* File: dbrt_table_asserts.sv */
// bus response checks for the lookup table
`default_nettype none
module dbrt_table_asserts #(parameter integer CORE_COUNT = 14) (
  input wire logic mclk_i, resetn_i, psel_i, penable_i, pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i, prdata_o,
  input wire logic [3:0] pstrb_i,
  input wire logic pready_o, pslverr_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_setup; psel_i && !penable_i; endsequence
  sequence s_rd; pready_o && !pwrite_i; endsequence
  a_ready_next: assert property (s_setup |=> pready_o)
    else $error("no ready");
  a_ready_cause: assert property (pready_o |-> penable_i && $past(psel_i && !penable_i))
    else $error("stray ready");
  a_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("long ready");
  a_no_error: assert property (!pslverr_o)
    else $error("error raised");
  a_quiet_zero: assert property (!(pready_o && !pwrite_i) |-> prdata_o == 32'h0)
    else $error("data outside read");
  a_entry_zero: assert property (s_rd ##0 paddr_i[11:2] == 10'h0 |-> prdata_o == 32'h000C0007)
    else $error("entry 0");
  a_unmapped: assert property (s_rd ##0 paddr_i[11:2] > 10'h6 |-> prdata_o == 32'h0)
    else $error("unmapped");
  a_last_entry: assert property (s_rd ##0 paddr_i[11:2] == 10'h6 |->
    prdata_o == (CORE_COUNT >= 5 ? 32'h002F0003 : 32'h0)) else $error("entry 6");
  a_reset_quiet: assert property (disable iff (1'b0) !resetn_i |=>
    !pready_o && !pslverr_o && prdata_o == 32'h0) else $error("output after reset");
endmodule // dbrt_table_asserts
`default_nettype wire

/* File: dbrt_apb_host.sv */
// debugger side model driving the peripheral bus
`default_nettype none
module dbrt_apb_host (
  input wire logic mclk_i, pready_i,
  input wire logic [31:0] prdata_i,
  output logic psel_o, penable_o, pwrite_o,
  output logic [11:0] paddr_o,
  output logic [31:0] pwdata_o,
  output logic [3:0] pstrb_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {psel_o, penable_o, pwrite_o, paddr_o, pwdata_o, pstrb_o} = '0;
  // setup then access, held until ready is sampled or 8 clocks pass
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic ok);
    int n;
    @(negedge mclk_i);
    {psel_o, penable_o, pwrite_o, paddr_o, pwdata_o, pstrb_o} = {2'h2, w, a, d, {4{w}}};
    @(negedge mclk_i);
    penable_o = 1'b1;
    n = 0;
    do
    begin
      @(posedge mclk_i);
      n++;
    end while (pready_i !== 1'b1 && n < 8);
    ok = pready_i;
    r = prdata_i;
  endtask
endmodule // dbrt_apb_host
`default_nettype wire

/* File: tb_top.sv */
// self-checking bench for the debug lookup table
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam integer CORE_COUNT = 4;
  localparam integer CORES_MIN = 1;
  localparam integer CORES_MAX = 14;
  logic mclk_i, resetn_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, ok;
  logic pready_min, pslverr_min, pready_max, pslverr_max;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, got, prdata_min, prdata_max;
  logic [3:0] pstrb_i;
  int n_mismatch, n_tests;
  int ofs_q[$] = '{20'h000C0, 20'h000F0, 20'h000F0, 20'h00170, 20'h001F0, 20'h00270, 20'h002F0};
  int need_q[$] = '{0, 0, 0, 2, 3, 4, 5};
  dbrt_table #(.CORE_COUNT(CORE_COUNT)) uut (.mclk_i(mclk_i), .resetn_i(resetn_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o));
  dbrt_apb_host host (.mclk_i(mclk_i), .pready_i(pready_o), .prdata_i(prdata_o),
    .psel_o(psel_i), .penable_o(penable_i), .pwrite_o(pwrite_i), .paddr_o(paddr_i),
    .pwdata_o(pwdata_i), .pstrb_o(pstrb_i));
  dbrt_table #(.CORE_COUNT(CORES_MIN)) uut_min (.mclk_i(mclk_i), .resetn_i(resetn_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_min), .pready_o(pready_min),
    .pslverr_o(pslverr_min));
  dbrt_table #(.CORE_COUNT(CORES_MAX)) uut_max (.mclk_i(mclk_i), .resetn_i(resetn_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_max), .pready_o(pready_max),
    .pslverr_o(pslverr_max));
  function automatic logic [31:0] model(input int cores, input logic w, input logic [11:0] a);
    int i;
    i = a[11:2];
    if (w || i > 6 || cores < need_q[i])
      return 32'h0;
    return (ofs_q[i] << 12) | (i == 0 ? 32'h7 : 32'h3);
  endfunction
  task automatic check(input logic w, input logic [11:0] a, input logic [31:0] d);
    host.xfer(w, a, d, got, ok);
    n_tests++;
    if (ok !== 1'b1 || pslverr_o !== 1'b0 || got !== model(CORE_COUNT, w, a))
    begin
      n_mismatch++;
      $display("ERROR %0t addr %h got %h", $time, a, got);
    end
    if ({pready_min, pslverr_min} !== 2'h2 || prdata_min !== model(CORES_MIN, w, a))
    begin
      n_mismatch++;
      $display("ERROR %0t addr %h low core count got %h", $time, a, prdata_min);
    end
    if ({pready_max, pslverr_max} !== 2'h2 || prdata_max !== model(CORES_MAX, w, a))
    begin
      n_mismatch++;
      $display("ERROR %0t addr %h high core count got %h", $time, a, prdata_max);
    end
  endtask
  task automatic give_verdict;
    if (n_mismatch == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end
  initial
  begin
    resetn_i = 1'b0;
    void'($urandom(32'h765A));
    repeat (4) @(negedge mclk_i);
    resetn_i = 1'b1;
    for (int i = 0; i < 8; i++) check(1'b0, 12'(i * 4), 32'h0);
    for (int k = 0; k < 60; k++) check(1'($urandom), 12'($urandom % 40), $urandom);
    @(negedge mclk_i);
    resetn_i = 1'b0;
    repeat (2) @(negedge mclk_i);
    resetn_i = 1'b1;
    for (int i = 0; i < 8; i++) check(1'b0, 12'(i * 4 + i % 4), 32'h0);
    check(1'b0, 12'hFFC, 32'h0);
    give_verdict();
  end
  initial
  begin
    #5000;
    n_mismatch++;
    give_verdict();
  end
endmodule // tb_top
bind dbrt_table dbrt_table_asserts #(.CORE_COUNT(CORE_COUNT)) u_chk (.mclk_i(mclk_i),
  .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pstrb_i(pstrb_i),
  .pready_o(pready_o), .pslverr_o(pslverr_o));
`default_nettype wire
